// file: sfdq_read.sv
`timescale 1ns/100ps
// Functional notes
// - address sampled rising, data shifted falling edge
// - address increments per byte, wraps to zero
// - dual read moves two bits per clock in address, dummy and data phases; command is one bit per clock
// - dual: command, 24-bit address, dummy, data
// - code BB selects dual io read
// - reads ignored while write cycle runs
// - chip select high stops data, ends instruction
// - quad: only data phase four bits wide
// - quad: command, 3-byte address, 8 dummy, data
// - any start byte accepted, no alignment
// - code 6B selects quad output read only when the quad enable bit is set
// - write in progress blocks reads

// ============================================================
// data fifo
module sfdq_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic push, pop;

    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign push = in_valid_i & in_ready_o & ~flush_i;
    assign pop = out_valid_o & out_ready_i & ~flush_i;

    always_comb
    begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
        if (flush_i)
        begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count = '0;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
        if (push)
        begin
            mem[wr_ptr] <= in_data_i;
        end
    end
endmodule

// ============================================================
// read sequencer
module sfdq_read
    import sfdq_pkg::*;
#(
    parameter int ADDR_W = SFDQ_ADDR_W,
    parameter int DEPTH = SFDQ_FIFO_DEPTH
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic [3:0] io_i,
    output logic [3:0] io_o,
    output logic [3:0] io_oe_o,
    input wire logic write_in_progress_bit_i,
    input wire logic quad_enable_bit_i,
    output logic fetch_valid_o,
    input wire logic fetch_ready_i,
    output logic [ADDR_W-1:0] fetch_addr_o,
    input wire logic mem_valid_i,
    output logic mem_ready_o,
    input wire logic [SFDQ_DATA_W-1:0] mem_data_i
);
    // ============================================================
    // pin synchronisers
    sfdq_pins_t pin_s1, pin_s2, pin_s3;
    logic rise, fall, cs_hi;

    always_ff @(posedge mclk_i)
    begin
        pin_s1 <= '{cs_n: cs_n_i, sclk: sclk_i, io: io_i};
        pin_s2 <= pin_s1;
        pin_s3 <= pin_s2;
    end

    assign rise = pin_s2.sclk & ~pin_s3.sclk;
    assign fall = ~pin_s2.sclk & pin_s3.sclk;
    assign cs_hi = pin_s2.cs_n;

    // ============================================================
    // fifo in the data path
    logic fifo_valid, fifo_pop;
    logic [SFDQ_DATA_W-1:0] fifo_data;

    sfdq_fifo #(
        .WIDTH(SFDQ_DATA_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .flush_i(cs_hi),
        .in_valid_i(mem_valid_i),
        .in_ready_o(mem_ready_o),
        .in_data_i(mem_data_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_data)
    );

    // ============================================================
    // sequencer
    sfdq_state_t state, next_state;
    logic quad, next_quad;
    logic [4:0] cnt, next_cnt;
    logic [7:0] cmd, next_cmd;
    logic [ADDR_W-1:0] addr, next_addr, fetch_addr, next_fetch_addr;
    logic [7:0] obyte, next_obyte;
    logic [1:0] part, next_part;
    logic [$clog2(DEPTH):0] credits, next_credits;
    sfdq_drive_t drv, next_drv;
    logic fetch_go;

    function automatic logic [4:0] last_clk(input int clks);
        return 5'(clks - 1);
    endfunction

    assign fetch_valid_o = ((state == SFDQ_ST_DUMMY) || (state == SFDQ_ST_DATA)) && !cs_hi
        && (credits < ($clog2(DEPTH)+1)'(DEPTH));
    assign fetch_go = fetch_valid_o & fetch_ready_i;
    assign fetch_addr_o = fetch_addr;
    assign io_o = drv.dout;
    assign io_oe_o = drv.oe;

    always_comb
    begin
        logic [7:0] val;
        val = SFDQ_BYTE_RST;
        next_state = state;
        next_quad = quad;
        next_cnt = cnt;
        next_cmd = cmd;
        next_addr = addr;
        next_obyte = obyte;
        next_part = part;
        next_drv = drv;
        next_fetch_addr = fetch_go ? fetch_addr + 1'b1 : fetch_addr;
        fifo_pop = 1'b0;
        if (cs_hi)
        begin
            next_state = SFDQ_ST_CMD;
            next_cnt = '0;
            next_drv = '0;
        end
        else
        begin
            unique case (state)
                SFDQ_ST_CMD:
                begin
                    if (rise)
                    begin
                        next_cmd = {cmd[6:0], pin_s2.io[0]};
                        next_cnt = cnt + 1'b1;
                        if (cnt == last_clk(SFDQ_CMD_CLKS))
                        begin
                            next_cnt = '0;
                            next_state = SFDQ_ST_IGNORE;
                            if (!write_in_progress_bit_i)
                            begin
                                if (next_cmd == SFDQ_CMD_DUAL_IO_READ)
                                begin
                                    next_state = SFDQ_ST_ADDR;
                                    next_quad = 1'b0;
                                end
                                if (next_cmd == SFDQ_CMD_QUAD_OUTPUT_READ
                                    && quad_enable_bit_i)
                                begin
                                    next_state = SFDQ_ST_ADDR;
                                    next_quad = 1'b1;
                                end
                            end
                        end
                    end
                end
                SFDQ_ST_ADDR:
                begin
                    if (rise)
                    begin
                        next_cnt = cnt + 1'b1;
                        if (quad)
                        begin
                            next_addr = {addr[ADDR_W-2:0], pin_s2.io[0]};
                        end
                        else
                        begin
                            next_addr = {addr[ADDR_W-3:0], pin_s2.io[1:0]};
                        end
                        if (cnt == last_clk(quad ? SFDQ_QUAD_ADDR_CLKS : SFDQ_DUAL_ADDR_CLKS))
                        begin
                            next_cnt = '0;
                            next_state = SFDQ_ST_DUMMY;
                            next_fetch_addr = next_addr;
                        end
                    end
                end
                SFDQ_ST_DUMMY:
                begin
                    if (rise)
                    begin
                        next_cnt = cnt + 1'b1;
                        if (cnt == last_clk(quad ? SFDQ_QUAD_DUMMY_CLKS : SFDQ_DUAL_DUMMY_CLKS))
                        begin
                            next_cnt = '0;
                            next_part = '0;
                            next_state = SFDQ_ST_DATA;
                        end
                    end
                end
                SFDQ_ST_DATA:
                begin
                    if (fall)
                    begin
                        val = obyte;
                        if (part == '0)
                        begin
                            val = fifo_valid ? fifo_data : SFDQ_BYTE_RST;
                            fifo_pop = fifo_valid;
                        end
                        if (quad)
                        begin
                            next_drv = '{oe: SFDQ_OE_QUAD, dout: val[7:4]};
                            next_obyte = {val[3:0], 4'h0};
                            next_part = (part == 2'd1) ? 2'd0 : part + 1'b1;
                        end
                        else
                        begin
                            next_drv = '{oe: SFDQ_OE_DUAL, dout: {2'b00, val[7:6]}};
                            next_obyte = {val[5:0], 2'b00};
                            next_part = part + 1'b1;
                        end
                    end
                end
                SFDQ_ST_IGNORE:
                begin
                    next_drv = '0;
                end
            endcase
        end
        next_credits = credits + ($clog2(DEPTH)+1)'(fetch_go) - ($clog2(DEPTH)+1)'(fifo_pop);
        if (cs_hi)
        begin
            next_credits = '0;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            state <= SFDQ_ST_CMD;
            quad <= 1'b0;
            cnt <= '0;
            cmd <= SFDQ_BYTE_RST;
            addr <= SFDQ_ADDR_RST;
            fetch_addr <= SFDQ_ADDR_RST;
            obyte <= SFDQ_BYTE_RST;
            part <= '0;
            credits <= '0;
            drv <= '{oe: SFDQ_NIB_RST, dout: SFDQ_NIB_RST};
        end
        else
        begin
            state <= next_state;
            quad <= next_quad;
            cnt <= next_cnt;
            cmd <= next_cmd;
            addr <= next_addr;
            fetch_addr <= next_fetch_addr;
            obyte <= next_obyte;
            part <= next_part;
            credits <= next_credits;
            drv <= next_drv;
        end
    end

    // ============================================================
    // assertions
    logic cmd_done;
    assign cmd_done = (state == SFDQ_ST_CMD) && rise && !cs_hi
        && (cnt == last_clk(SFDQ_CMD_CLKS));

    property p_drive_only_in_data;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (io_oe_o != 4'h0) |-> (state == SFDQ_ST_DATA);
    endproperty
    a_drive_only_in_data: assert property (p_drive_only_in_data)
        else $error("io lines driven outside data phase");

    property p_upper_quiet;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (io_oe_o[3:2] != 2'b00) |-> quad && (state == SFDQ_ST_DATA);
    endproperty
    a_upper_quiet: assert property (p_upper_quiet)
        else $error("upper io lines driven outside quad data");

    property p_cs_stops;
        @(posedge mclk_i) disable iff (!rst_n_i)
        cs_hi |=> (io_oe_o == 4'h0) && (state == SFDQ_ST_CMD);
    endproperty
    a_cs_stops: assert property (p_cs_stops)
        else $error("drive not released after chip select high");

    property p_busy_rejects;
        @(posedge mclk_i) disable iff (!rst_n_i)
        cmd_done && write_in_progress_bit_i |=> (state == SFDQ_ST_IGNORE);
    endproperty
    a_busy_rejects: assert property (p_busy_rejects)
        else $error("read accepted during write cycle");

    property p_dual_decode;
        @(posedge mclk_i) disable iff (!rst_n_i)
        cmd_done && !write_in_progress_bit_i
        && ({cmd[6:0], pin_s2.io[0]} == SFDQ_CMD_DUAL_IO_READ)
        |=> (state == SFDQ_ST_ADDR) && !quad;
    endproperty
    a_dual_decode: assert property (p_dual_decode)
        else $error("dual io read not decoded");

    property p_quad_decode;
        @(posedge mclk_i) disable iff (!rst_n_i)
        cmd_done && !write_in_progress_bit_i && quad_enable_bit_i
        && ({cmd[6:0], pin_s2.io[0]} == SFDQ_CMD_QUAD_OUTPUT_READ)
        |=> (state == SFDQ_ST_ADDR) && quad;
    endproperty
    a_quad_decode: assert property (p_quad_decode)
        else $error("quad output read not decoded");

    property p_addr_step;
        @(posedge mclk_i) disable iff (!rst_n_i)
        fetch_go && (state == SFDQ_ST_DATA) && !cs_hi
        |=> fetch_addr_o == $past(fetch_addr_o) + 1'b1;
    endproperty
    a_addr_step: assert property (p_addr_step)
        else $error("fetch address did not advance by one");

    property p_out_on_fall;
        @(posedge mclk_i) disable iff (!rst_n_i)
        $changed(io_o) && !$past(cs_hi) |-> $past(fall);
    endproperty
    a_out_on_fall: assert property (p_out_on_fall)
        else $error("data changed without a falling clock");

    property p_msb_first;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (state == SFDQ_ST_DATA) && fall && !cs_hi && (part == 2'd0) && fifo_valid && !quad
        |=> io_o[1:0] == $past(fifo_data[7:6]);
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("byte not sent high bits first");

    c_dual_data: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state == SFDQ_ST_DATA) && !quad && fall);
    c_quad_data: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state == SFDQ_ST_DATA) && quad && fall);
    c_rejected: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        cmd_done && write_in_progress_bit_i);
endmodule

// file: sfdq_pkg.sv
package sfdq_pkg;

    // ============================================================
    // instruction codes and phase lengths
    localparam logic [7:0] SFDQ_CMD_DUAL_IO_READ = 8'hBB;
    localparam logic [7:0] SFDQ_CMD_QUAD_OUTPUT_READ = 8'h6B;
    localparam int SFDQ_CMD_CLKS = 8;
    localparam int SFDQ_DUAL_ADDR_CLKS = 12;
    localparam int SFDQ_QUAD_ADDR_CLKS = 24;
    localparam int SFDQ_DUAL_DUMMY_CLKS = 4;
    localparam int SFDQ_QUAD_DUMMY_CLKS = 8;
    localparam int SFDQ_ADDR_W = 24;
    localparam int SFDQ_DATA_W = 8;
    localparam int SFDQ_FIFO_DEPTH = 32;

    // ============================================================
    // reset values and output enable patterns
    localparam logic [SFDQ_ADDR_W-1:0] SFDQ_ADDR_RST = 24'h00_0000;
    localparam logic [7:0] SFDQ_BYTE_RST = 8'h00;
    localparam logic [3:0] SFDQ_NIB_RST = 4'h0;
    localparam logic [3:0] SFDQ_OE_DUAL = 4'h3;
    localparam logic [3:0] SFDQ_OE_QUAD = 4'hF;

    typedef enum logic [2:0] {
        SFDQ_ST_CMD,
        SFDQ_ST_ADDR,
        SFDQ_ST_DUMMY,
        SFDQ_ST_DATA,
        SFDQ_ST_IGNORE
    } sfdq_state_t;

    // pins as sampled from the link
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic [3:0] io;
    } sfdq_pins_t;

    // drive toward the io lines
    typedef struct packed {
        logic [3:0] oe;
        logic [3:0] dout;
    } sfdq_drive_t;

endpackage

// file: sfdq_host_model.sv
`timescale 1ns/100ps
// ============================================================
// host controller: drives the link, collects returned bytes
module sfdq_host_model (
    input wire logic [3:0] dev_io_i,
    input wire logic [3:0] dev_oe_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic [3:0] io_o,
    output logic rx_stb_o,
    output logic [7:0] rx_byte_o,
    output int drv_err_o
);
    logic [3:0] host_io = 4'h0;
    logic [3:0] host_oe = 4'h0;
    logic [3:0] pat = 4'h5;
    initial
    begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        rx_stb_o = 1'b0;
        rx_byte_o = 8'h00;
        drv_err_o = 0;
    end
    // released lines toggle so a stale level never passes
    always #50 pat = ~pat;
    assign io_o = (dev_oe_i & dev_io_i) | (~dev_oe_i & host_oe & host_io) | (~dev_oe_i & ~host_oe & pat);

    // bits change on the fall, device takes them on the rise
    task automatic tick(input logic [3:0] v, input logic [3:0] oe);
        host_io = v;
        host_oe = oe;
        #200 sclk_o = 1'b1;
        if (dev_oe_i !== 4'h0) drv_err_o++;
        #200 sclk_o = 1'b0;
    endtask

    task automatic frame(input logic [7:0] cmd, input logic [23:0] addr, input logic quad,
                         input int nslots, input logic [3:0] exp_oe);
        int i;
        logic [7:0] sh;
        logic [3:0] dm;
        // dummy level per frame: both lines all zero or all one
        dm = ($urandom % 2) ? 4'h3 : 4'h0;
        #13 cs_n_o = 1'b0;
        for (i = 7; i >= 0; i--) tick({3'b000, cmd[i]}, 4'h1);
        if (quad)
        begin
            for (i = 23; i >= 0; i--) tick({3'b000, addr[i]}, 4'h1);
            for (i = 0; i < 8; i++) tick(4'h0, 4'h1);
        end
        else
        begin
            for (i = 22; i >= 0; i -= 2) tick({2'b00, addr[i+1], addr[i]}, 4'h3);
            for (i = 0; i < 4; i++) tick(dm, 4'h3);
        end
        host_oe = 4'h0;
        sh = 8'h00;
        for (i = 0; i < nslots; i++)
        begin
            #200 sclk_o = 1'b1;
            #190;
            if (dev_oe_i !== exp_oe) drv_err_o++;
            sh = quad ? {sh[3:0], io_o} : {sh[5:0], io_o[1:0]};
            if (exp_oe != 4'h0 && (i + 1) % (quad ? 2 : 4) == 0)
            begin
                rx_byte_o = sh;
                rx_stb_o = 1'b1;
            end
            #10 sclk_o = 1'b0;
            rx_stb_o = 1'b0;
        end
        #200 cs_n_o = 1'b1;
        #400;
        if (dev_oe_i !== 4'h0) drv_err_o++;
        #400;
    endtask
endmodule

// file: testbench.sv
`timescale 1ns/100ps
module testbench;
    import sfdq_pkg::*;
    logic mclk_i;
    logic rst_n_i;
    logic write_in_progress_bit;
    logic qe;
    logic fetch_ready = 1'b0;
    logic mem_valid = 1'b0;
    logic [7:0] mem_data = 8'h00;
    logic cs_n;
    logic sclk;
    logic [3:0] io_wire;
    logic [3:0] dev_io;
    logic [3:0] dev_oe;
    logic fetch_valid;
    logic [23:0] fetch_addr;
    logic mem_ready;
    logic rx_stb;
    logic [7:0] rx_byte;
    int drv_err;
    int bad_count;
    int n_checks;
    logic took;
    logic [23:0] a;
    logic [7:0] exp_q[$];
    logic [23:0] pend[$];

    sfdq_read dut_u (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sclk_i(sclk), .io_i(io_wire),
        .io_o(dev_io), .io_oe_o(dev_oe), .write_in_progress_bit_i(write_in_progress_bit),
        .quad_enable_bit_i(qe), .fetch_valid_o(fetch_valid), .fetch_ready_i(fetch_ready),
        .fetch_addr_o(fetch_addr), .mem_valid_i(mem_valid), .mem_ready_o(mem_ready),
        .mem_data_i(mem_data)
    );
    sfdq_host_model host_u (
        .dev_io_i(dev_io), .dev_oe_i(dev_oe), .cs_n_o(cs_n), .sclk_o(sclk), .io_o(io_wire),
        .rx_stb_o(rx_stb), .rx_byte_o(rx_byte), .drv_err_o(drv_err)
    );

    initial
    begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    function automatic logic [7:0] mem_byte(input logic [23:0] ad);
        return (ad[7:0] ^ 8'h3C) + ad[23:16];
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
            bad_count++;
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic run(input string name, input logic [7:0] cmd, input logic [23:0] ad,
                       input logic quad, input int nslots, input logic [3:0] oe, input int nb);
        int i;
        for (i = 0; i < nb; i++) exp_q.push_back(mem_byte(ad + 24'(i)));
        host_u.frame(cmd, ad, quad, nslots, oe);
        chk("drive errors", 32'h0000_0000, 32'(drv_err));
        chk("bytes missing", 32'h0000_0000, 32'(exp_q.size()));
        $display("test %s done", name);
    endtask

    // ============================================================
    // memory behind the fetch port, random stalls and latency
    always @(posedge mclk_i)
    begin
        took = mem_valid && mem_ready;
        if (took) void'(pend.pop_front());
        if (fetch_valid && fetch_ready) pend.push_back(fetch_addr);
        if (cs_n) pend.delete();
        #1 fetch_ready = ($urandom % 4) != 0;
        if (took || !mem_valid) mem_valid = (pend.size() > 0) && ($urandom % 2);
        if (pend.size() == 0) mem_valid = 1'b0;
        mem_data = (pend.size() > 0) ? mem_byte(pend[0]) : ~mem_data;
    end

    // ============================================================
    // compare each returned byte with the oldest expectation
    always @(posedge rx_stb)
    begin
        // let the byte settle through the port before looking at it
        #1;
        if (exp_q.size() == 0)
            chk("unexpected byte", 32'h0000_0000, 32'h0000_0001);
        else
            chk("read byte", 32'(exp_q.pop_front()), 32'(rx_byte));
    end

    initial
    begin
        repeat (100000) @(posedge mclk_i);
        bad_count++;
        stop_test;
    end

    initial
    begin
        rst_n_i = 1'b0;
        write_in_progress_bit = 1'b0;
        qe = 1'b0;
        bad_count = 0;
        n_checks = 0;
        void'($urandom(68));
        repeat (10) @(posedge mclk_i);
        #1 rst_n_i = 1'b1;
        repeat (5) @(posedge mclk_i);
        a = 24'($urandom) | 24'h00_0001;
        run("dual", SFDQ_CMD_DUAL_IO_READ, a, 1'b0, 20, SFDQ_OE_DUAL, 5);
        @(posedge mclk_i) #1 qe = 1'b1;
        a = 24'($urandom) | 24'h00_0001;
        run("quad", SFDQ_CMD_QUAD_OUTPUT_READ, a, 1'b1, 10, SFDQ_OE_QUAD, 5);
        run("dual wrap", SFDQ_CMD_DUAL_IO_READ, 24'hFF_FFFE, 1'b0, 16, SFDQ_OE_DUAL, 4);
        run("quad wrap", SFDQ_CMD_QUAD_OUTPUT_READ, 24'hFF_FFFF, 1'b1, 6, SFDQ_OE_QUAD, 3);
        run("dual abort", SFDQ_CMD_DUAL_IO_READ, a, 1'b0, 6, SFDQ_OE_DUAL, 1);
        run("quad abort", SFDQ_CMD_QUAD_OUTPUT_READ, a, 1'b1, 3, SFDQ_OE_QUAD, 1);
        @(posedge mclk_i) #1 qe = 1'b0;
        run("quad no enable", SFDQ_CMD_QUAD_OUTPUT_READ, a, 1'b1, 4, 4'h0, 0);
        @(posedge mclk_i) #1 qe = 1'b1;
        @(posedge mclk_i) #1 write_in_progress_bit = 1'b1;
        run("dual busy", SFDQ_CMD_DUAL_IO_READ, a, 1'b0, 8, 4'h0, 0);
        run("quad busy", SFDQ_CMD_QUAD_OUTPUT_READ, a, 1'b1, 4, 4'h0, 0);
        @(posedge mclk_i) #1 write_in_progress_bit = 1'b0;
        run("bad code", 8'h03, a, 1'b0, 8, 4'h0, 0);
        run("after busy", SFDQ_CMD_DUAL_IO_READ, a, 1'b0, 8, SFDQ_OE_DUAL, 2);
        stop_test;
    end
endmodule
